/* hdl/smsc_pkg.sv */
// Purpose : constants and carrier types for the mode and supply control registers
// Assumes : 16-bit serial frames, msb first, byte-wide registers
// Notes   : shared by the register bank and the verification side
package smsc_pkg;
  // ----------------------------------------------------------------------
  // frame and addresses
  // ----------------------------------------------------------------------
  localparam int unsigned FRAME_BITS       = 16;
  localparam logic [6:0]  ADDR_MODE_SUPPLY = 7'h01;
  localparam logic [6:0]  ADDR_HW_CTRL0    = 7'h02;
  localparam int unsigned FRM_WRITE_BIT    = 7;

  // ----------------------------------------------------------------------
  // field positions of mode_and_supply_control
  // ----------------------------------------------------------------------
  localparam int unsigned MS_MODE_HI   = 7;
  localparam int unsigned MS_MODE_LO   = 6;
  localparam int unsigned MS_EXT_EN    = 5;
  localparam int unsigned MS_OV_REACT  = 2;
  localparam int unsigned MS_RT_HI     = 1;
  localparam int unsigned MS_RT_LO     = 0;
  localparam logic [7:0]  MS_WR_MASK   = 8'he7;
  localparam logic [7:0]  MS_KEEP_MASK = 8'h23;
  localparam logic [7:0]  MS_RESET     = 8'h00;

  // ----------------------------------------------------------------------
  // field positions of hardware_control_zero
  // ----------------------------------------------------------------------
  localparam int unsigned HW_PWM_LAG   = 6;
  localparam int unsigned HW_FO_FORCE  = 5;
  localparam int unsigned HW_BUCK_PWM_BY_WAKE_PIN = 4;
  localparam int unsigned HW_PWM_AUTO  = 3;
  localparam int unsigned HW_BOOST_EN  = 1;
  localparam int unsigned HW_FO_CFG    = 0;
  localparam logic [7:0]  HW_WR_MASK   = 8'h7b;
  localparam logic [7:0]  HW_KEEP_MASK = 8'h5f;
  localparam logic [7:0]  HW_RESET     = 8'h00;

  // ----------------------------------------------------------------------
  // mode encodings and timing
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SLEEP  = 2'h1;
  localparam logic [1:0] MODE_STOP   = 2'h2;
  localparam logic [1:0] MODE_SOFT   = 2'h3;

  localparam int unsigned CLK_MHZ       = 125;
  localparam int unsigned LAG_SHORT_US  = 100;
  localparam int unsigned LAG_LONG_US   = 1000;
  localparam int unsigned LAG_SHORT_CYC = LAG_SHORT_US * CLK_MHZ;
  localparam int unsigned LAG_LONG_CYC  = LAG_LONG_US * CLK_MHZ;
  localparam int unsigned LAG_W         = 17;

  typedef enum logic [1:0] {SMSC_IDLE, SMSC_SHIFT} smsc_fsm_t;

  typedef struct packed {
    logic sck;
    logic csn;
    logic mosi;
  } smsc_spi_in_t;

  typedef struct packed {
    logic ext_supply_on;
    logic ov_react_en;
    logic [1:0] io_rt_sel;
    logic pwm_lag_long;
    logic boost_en;
    logic fo_cfg_sel;
    logic fail_output;
    logic buck_pwm;
    logic [1:0] mode;
    logic soft_reset;
    logic ov_restart_req;
  } smsc_ctrl_out_t;
endpackage

/* hdl/smsc_regs.sv */
// Purpose : mode/supply and hardware control registers behind a 16-bit serial port
// Assumes : host is serial master, mode 0, frame = addr[6:0], write bit, data byte
// Notes   : other register addresses read as zero and ignore writes
//
// Behaviour
// - mode field bits 7:6 select normal, sleep, stop or soft reset.
// - a serial write cannot move the chip from stop straight to sleep.
// - entering restart rewrites the mode field to normal.
// - data shifted out during a write shows the contents before that write.
// - bit 5 switches the external supply output on.
// - reserved bits are read-only and read zero.
// - overvoltage sets its flag; bit 2 alone allows restart or fail-safe.
// - bits 1:0 pick one of four io supply reset thresholds.
// - mode register clears on reset; restart keeps bit 5 and bits 1:0.
// - hardware register clears on reset; restart clears bits 7 and 5.
// - bit 6 sets pwm to pfm lag: 100 us or 1 ms.
// - bit 5 forces the fail output; otherwise failures alone drive it.
// - restart clears the force bit; a live failure keeps the output active.
// - in stop, bit 4 lets the wake pin switch the buck pfm or pwm.
// - in stop, bit 3 allows automatic pfm to pwm on heavy load.
// - after automatic pwm, only a mode register write that leaves stop selected (a refused sleep write too) returns to pfm.
// - bit 1 enables the boost converter, auto-on at low battery.
// - bit 0 selects fail output configuration; 0 fails after second trigger.
// - interrupt config pin level picks the configuration pair.
// - frame holds 7-bit address, write bit 8 and one data byte.
// - restart keeps bits marked x and forces the printed ones.
`timescale 1ns/100ps

module smsc_regs (
  // clock and reset
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst,
  // serial port pins
  input  wire smsc_pkg::smsc_spi_in_t i_spi,
  output logic                       o_spi_miso,
  // chip events
  input  wire logic                  i_restart,
  input  wire logic                  i_io_overvoltage,
  input  wire logic                  i_failure_active,
  input  wire logic                  i_high_voltage_wake_pin,
  input  wire logic                  i_buck_heavy_load,
  input  wire logic                  i_interrupt_config_pin,
  // controls and status
  output smsc_pkg::smsc_ctrl_out_t   o_ctrl,
  output logic                       o_io_overvoltage_flag,
  output logic                       o_fail_safe_vcc_off_cfg
);

  typedef struct packed {
    logic                           sck_prev;
    smsc_pkg::smsc_fsm_t            fsm;
    logic [3:0]                     bit_cnt;
    logic [15:0]                    rx;
    logic [7:0]                     tx;
    logic                           miso;
    logic [7:0]                     ms;
    logic [7:0]                     hw;
    logic                           ov_flag;
    logic                           auto_pwm;
    logic                           pwm_cmd;
    logic [smsc_pkg::LAG_W-1:0]     lag_cnt;
    logic                           cfg_pin;
    smsc_pkg::smsc_ctrl_out_t       ctrl;
  } smsc_state_t;

  smsc_state_t s_q, s_d;
  logic        sck_w, csn_w, mosi_w;
  logic        wake_w, cfg_w;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  // serial, wake and config pins pass two flops; nothing reads the first one
  smsc_sync2 #(
    .RESET_VAL (1'b0)
  ) u_sync_sck (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_pin     (i_spi.sck),
    .o_level   (sck_w)
  );

  smsc_sync2 #(
    .RESET_VAL (1'b1)
  ) u_sync_csn (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_pin     (i_spi.csn),
    .o_level   (csn_w)
  );

  smsc_sync2 #(
    .RESET_VAL (1'b0)
  ) u_sync_mosi (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_pin     (i_spi.mosi),
    .o_level   (mosi_w)
  );

  smsc_sync2 #(
    .RESET_VAL (1'b0)
  ) u_sync_wake (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_pin     (i_high_voltage_wake_pin),
    .o_level   (wake_w)
  );

  smsc_sync2 #(
    .RESET_VAL (1'b0)
  ) u_sync_cfg (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_pin     (i_interrupt_config_pin),
    .o_level   (cfg_w)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // edge detector clears to low on reset, the idle level of sck, so no false edge
    s_d.sck_prev = sck_w;
    s_d.ctrl.soft_reset = 1'b0;

    // --------------------------------------------------------------------
    // serial frame
    // --------------------------------------------------------------------
    case (s_q.fsm)
      smsc_pkg::SMSC_IDLE: begin
        s_d.bit_cnt = 4'h0;
        if (!csn_w) begin
          s_d.fsm = smsc_pkg::SMSC_SHIFT;
        end
      end
      smsc_pkg::SMSC_SHIFT: begin
        if (csn_w) begin
          s_d.fsm = smsc_pkg::SMSC_IDLE;
        end else if (sck_w && !s_q.sck_prev) begin
          s_d.rx = {s_q.rx[14:0], mosi_w};
          s_d.bit_cnt = s_q.bit_cnt + 4'h1;
          if (s_q.bit_cnt == 4'h7) begin
            // address byte complete: preload old contents for the data byte
            case (s_q.rx[6:0])
              smsc_pkg::ADDR_MODE_SUPPLY: s_d.tx = s_q.ms;
              smsc_pkg::ADDR_HW_CTRL0:    s_d.tx = s_q.hw;
              default:                    s_d.tx = 8'h00;
            endcase
          end
          if (s_q.bit_cnt == 4'hf) begin
            s_d.fsm = smsc_pkg::SMSC_IDLE;
            // fifteen bits are in, so the access bit now sits at position 7
            if (s_q.rx[smsc_pkg::FRM_WRITE_BIT]) begin
              if (s_q.rx[14:8] == smsc_pkg::ADDR_MODE_SUPPLY) begin
                s_d.ms = {s_q.rx[6:0], mosi_w} & smsc_pkg::MS_WR_MASK;
                // stop to sleep refused: mode field held
                if (s_q.ms[7:6] == smsc_pkg::MODE_STOP &&
                    s_d.ms[7:6] == smsc_pkg::MODE_SLEEP) begin
                  s_d.ms[7:6] = smsc_pkg::MODE_STOP;
                end
                if (s_d.ms[7:6] == smsc_pkg::MODE_STOP) begin
                  s_d.auto_pwm = 1'b0;
                end
                if (s_d.ms[7:6] == smsc_pkg::MODE_SOFT) begin
                  s_d.ctrl.soft_reset = 1'b1;
                end
              end else if (s_q.rx[14:8] == smsc_pkg::ADDR_HW_CTRL0) begin
                s_d.hw = {s_q.rx[6:0], mosi_w} & smsc_pkg::HW_WR_MASK;
              end
            end
          end
        end else if (!sck_w && s_q.sck_prev) begin
          // shift out on falling edge, msb first during the data byte
          s_d.miso = s_q.tx[7];
          if (s_q.bit_cnt >= 4'h8) begin
            s_d.tx = {s_q.tx[6:0], 1'b0};
          end
        end
      end
      default: s_d.fsm = smsc_pkg::SMSC_IDLE;
    endcase

    // --------------------------------------------------------------------
    // overvoltage flag: sticky here, cleared only by reset or a soft reset
    // --------------------------------------------------------------------
    if (i_io_overvoltage) begin
      s_d.ov_flag = 1'b1;
    end

    // --------------------------------------------------------------------
    // restart: x bits kept, printed bits forced
    // --------------------------------------------------------------------
    if (i_restart) begin
      s_d.ms = s_d.ms & smsc_pkg::MS_KEEP_MASK;
      s_d.hw = s_d.hw & smsc_pkg::HW_KEEP_MASK;
    end

    // --------------------------------------------------------------------
    // buck regulation in stop mode
    // --------------------------------------------------------------------
    if (s_d.ms[7:6] == smsc_pkg::MODE_STOP && s_d.hw[smsc_pkg::HW_PWM_AUTO] &&
        i_buck_heavy_load) begin
      s_d.auto_pwm = 1'b1;
    end
    if (s_d.ms[7:6] != smsc_pkg::MODE_STOP) begin
      s_d.pwm_cmd = 1'b1;
    end else begin
      s_d.pwm_cmd = s_d.auto_pwm ||
                    (s_d.hw[smsc_pkg::HW_BUCK_PWM_BY_WAKE_PIN] && wake_w);
    end
    // lag before pwm falls back to pfm
    if (s_d.pwm_cmd) begin
      s_d.lag_cnt = s_q.hw[smsc_pkg::HW_PWM_LAG] ?
                    smsc_pkg::LAG_W'(smsc_pkg::LAG_LONG_CYC) :
                    smsc_pkg::LAG_W'(smsc_pkg::LAG_SHORT_CYC);
      s_d.ctrl.buck_pwm = 1'b1;
    end else if (s_q.lag_cnt != '0) begin
      s_d.lag_cnt = s_q.lag_cnt - smsc_pkg::LAG_W'(1);
    end else begin
      s_d.ctrl.buck_pwm = 1'b0;
    end

    // --------------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------------
    s_d.cfg_pin = cfg_w;
    s_d.ctrl.mode           = s_d.ms[7:6];
    s_d.ctrl.ext_supply_on  = s_d.ms[smsc_pkg::MS_EXT_EN];
    s_d.ctrl.ov_react_en    = s_d.ms[smsc_pkg::MS_OV_REACT];
    s_d.ctrl.ov_restart_req = i_io_overvoltage && s_q.ms[smsc_pkg::MS_OV_REACT];
    s_d.ctrl.io_rt_sel      = s_d.ms[1:0];
    s_d.ctrl.pwm_lag_long   = s_d.hw[smsc_pkg::HW_PWM_LAG];
    s_d.ctrl.boost_en       = s_d.hw[smsc_pkg::HW_BOOST_EN];
    s_d.ctrl.fo_cfg_sel     = s_d.hw[smsc_pkg::HW_FO_CFG];
    // failure keeps the output active whatever the force bit does
    s_d.ctrl.fail_output    = s_d.hw[smsc_pkg::HW_FO_FORCE] || i_failure_active;
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || s_q.ctrl.soft_reset) begin
      s_q        <= '0;
      // a live failure must keep the fail output up through a soft reset
      s_q.ctrl.fail_output <= i_failure_active;
      s_q.ms     <= smsc_pkg::MS_RESET;
      s_q.hw     <= smsc_pkg::HW_RESET;
      s_q.fsm    <= smsc_pkg::SMSC_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_spi_miso              = s_q.miso;
  assign o_ctrl                  = s_q.ctrl;
  assign o_io_overvoltage_flag   = s_q.ov_flag;
  assign o_fail_safe_vcc_off_cfg = s_q.cfg_pin;

endmodule // smsc_regs

// ----------------------------------------------------------------------
// two-flop synchroniser
// ----------------------------------------------------------------------
module smsc_sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  // pin in, level out
  input  wire logic i_pin,
  output logic      o_level
);

  typedef struct packed {
    logic stage1;
    logic stage2;
  } smsc_sync_state_t;

  smsc_sync_state_t s_q, s_d;

  always_comb begin
    s_d        = s_q;
    s_d.stage1 = i_pin;
    s_d.stage2 = s_q.stage1;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_q <= {RESET_VAL, RESET_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_level = s_q.stage2;

endmodule // smsc_sync2

/* sim/smsc_regs_properties.sv */
// Purpose : timing relations of the mode and supply control outputs
// Assumes : single clock, sync reset
// Notes   : serial register contents are judged by the bench
`timescale 1ns/100ps
module smsc_regs_properties (
  // clock and reset
  input wire logic                     i_sys_clk,
  input wire logic                     i_rst,
  // watched
  input wire logic                     i_restart,
  input wire logic                     i_io_overvoltage,
  input wire logic                     i_failure_active,
  input wire logic                     i_interrupt_config_pin,
  input wire smsc_pkg::smsc_ctrl_out_t o_ctrl,
  input wire logic                     o_io_overvoltage_flag,
  input wire logic                     o_fail_safe_vcc_off_cfg
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence s_restart2;
    i_restart ##1 i_restart;
  endsequence
  sequence s_cleared;
    o_ctrl.mode == smsc_pkg::MODE_NORMAL && !o_ctrl.ext_supply_on;
  endsequence
  property p_fo;
    i_failure_active ##1 i_failure_active |-> o_ctrl.fail_output;
  endproperty
  property p_ovf;
    i_io_overvoltage |-> ##[1:2] o_io_overvoltage_flag;
  endproperty
  property p_ovreq;
    !o_ctrl.ov_react_en ##1 !o_ctrl.ov_react_en |-> !o_ctrl.ov_restart_req;
  endproperty
  property p_nosleep;
    $past(o_ctrl.mode) == smsc_pkg::MODE_STOP |-> o_ctrl.mode != smsc_pkg::MODE_SLEEP;
  endproperty
  property p_restart;
    s_restart2 |=> o_ctrl.mode == smsc_pkg::MODE_NORMAL && !o_ctrl.ov_react_en;
  endproperty
  property p_keep;
    s_restart2 |=> $stable(o_ctrl.ext_supply_on) && $stable(o_ctrl.io_rt_sel)
      && $stable(o_ctrl.boost_en);
  endproperty
  property p_cfg;
    !$past(i_rst) && !$past(i_rst, 2) && !$past(i_rst, 3) && !$past(o_ctrl.soft_reset)
      |-> o_fail_safe_vcc_off_cfg == $past(i_interrupt_config_pin, 3);
  endproperty
  property p_soft;
    o_ctrl.soft_reset |=> !o_ctrl.soft_reset ##[0:2] s_cleared;
  endproperty
  a_fo: assert property (p_fo) else $error("fail output dropped");
  a_ovf: assert property (p_ovf) else $error("ov flag not set");
  a_ovreq: assert property (p_ovreq) else $error("ov restart while off");
  a_nosleep: assert property (p_nosleep) else $error("stop to sleep");
  a_restart: assert property (p_restart) else $error("restart no clear");
  a_keep: assert property (p_keep) else $error("restart lost bits");
  a_cfg: assert property (p_cfg) else $error("cfg pin copy");
  a_soft: assert property (p_soft) else $error("soft reset");
endmodule // smsc_regs_properties
bind smsc_regs smsc_regs_properties u_props (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_restart(i_restart), .i_io_overvoltage(i_io_overvoltage),
  .i_failure_active(i_failure_active), .i_interrupt_config_pin(i_interrupt_config_pin),
  .o_ctrl(o_ctrl), .o_io_overvoltage_flag(o_io_overvoltage_flag),
  .o_fail_safe_vcc_off_cfg(o_fail_safe_vcc_off_cfg));

/* sim/smsc_host_model.sv */
// Purpose : serial master standing in for the microcontroller
// Assumes : mode 0, msb first, 6 clocks per sck phase
// Notes   : sck idles low; mosi shows garbage between frames
`timescale 1ns/100ps
module smsc_host_model (
  input wire logic                i_sys_clk,
  input wire logic                i_spi_miso,
  output smsc_pkg::smsc_spi_in_t  o_spi
);
  initial o_spi = 3'h2;
  task automatic step(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic xfer(input logic [15:0] frm, output logic [7:0] rd);
    logic [15:0] sh;
    sh = 16'h0000;
    o_spi.csn = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      o_spi.mosi = frm[i];
      step(6);
      sh = {sh[14:0], i_spi_miso};
      o_spi.sck = 1'b1;
      step(6);
      o_spi.sck = 1'b0;
    end
    step(6);
    o_spi.csn = 1'b1;
    o_spi.mosi = ~o_spi.mosi;
    step(6);
    rd = sh[7:0];
  endtask
endmodule // smsc_host_model

/* sim/sbc_mode_supply_control_regs_tb_top.sv */
// Purpose : self-checking bench of the mode and supply registers
// Assumes : host model drives the serial port
// Notes   : inputs change 1 ns after the rising edge
`timescale 1ns/100ps
module sbc_mode_supply_control_regs_tb_top;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic rs, ov, fl, wk, ld, ic;
  logic miso, ovf, fsc;
  logic [7:0] r;
  int num_errors = 0;
  int n_checks = 0;
  smsc_pkg::smsc_spi_in_t   spi;
  smsc_pkg::smsc_ctrl_out_t c;
  always #4 i_sys_clk = ~i_sys_clk;
  smsc_host_model host (.i_sys_clk(i_sys_clk), .i_spi_miso(miso), .o_spi(spi));
  smsc_regs uut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_spi(spi), .o_spi_miso(miso),
    .i_restart(rs), .i_io_overvoltage(ov), .i_failure_active(fl),
    .i_high_voltage_wake_pin(wk), .i_buck_heavy_load(ld), .i_interrupt_config_pin(ic),
    .o_ctrl(c), .o_io_overvoltage_flag(ovf), .o_fail_safe_vcc_off_cfg(fsc));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer({a, 1'b1, d}, r);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    host.xfer({a, 1'b0, 8'h00}, r);
    chk("rdata", r, e);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // waits out the pwm to pfm lag; lo is the earliest count that still shows a lag
  task automatic pfm_wait(input string n, input int lo);
    int k;
    k = 0;
    while (c.buck_pwm !== 1'b0 && k < smsc_pkg::LAG_SHORT_CYC + 50) begin
      host.step(1);
      k++;
    end
    chk(n, 8'(c.buck_pwm), 8'h00);
    chk({n, "_lag"}, 8'(k >= lo && k <= smsc_pkg::LAG_SHORT_CYC + 2), 8'h01);
    if (c.buck_pwm !== 1'b0)
      conclude();
  endtask
  task automatic t_regs();
    rd(7'h01, 8'h00);
    rd(7'h02, 8'h00);
    wr(7'h01, 8'h3f);
    rd(7'h01, 8'h27);
    chk("ctl", 8'({c.ext_supply_on, c.ov_react_en, c.io_rt_sel}), 8'h0f);
    wr(7'h01, 8'h20);
    chk("old", r, 8'h27);
    wr(7'h02, 8'hff);
    rd(7'h02, 8'h7b);
    chk("hw", 8'({c.pwm_lag_long, c.boost_en, c.fo_cfg_sel, c.fail_output}), 8'h0f);
    rd(7'h05, 8'h00);
    $display("done regs");
  endtask
  task automatic t_stop();
    wr(7'h02, 8'h00);
    wk = 1'b1;
    ld = 1'b1;
    wr(7'h01, 8'h80);
    pfm_wait("pfm", smsc_pkg::LAG_SHORT_CYC - 20);
    wr(7'h01, 8'h40);
    rd(7'h01, 8'h80);
    chk("mode", 8'(c.mode), 8'(smsc_pkg::MODE_STOP));
    wr(7'h02, 8'h08);
    chk("auto", 8'(c.buck_pwm), 8'h01);
    ld = 1'b0;
    host.step(4);
    chk("latch", 8'(c.buck_pwm), 8'h01);
    wr(7'h01, 8'h80);
    pfm_wait("back", smsc_pkg::LAG_SHORT_CYC - 20);
    wr(7'h02, 8'h10);
    chk("wake", 8'(c.buck_pwm), 8'h01);
    wk = 1'b0;
    host.step(4);
    pfm_wait("wake0", smsc_pkg::LAG_SHORT_CYC - 20);
    $display("done stop");
  endtask
  task automatic t_ov();
    ov = 1'b1;
    host.step(3);
    ov = 1'b0;
    chk("ovoff", 8'({ovf, c.ov_restart_req}), 8'h02);
    wr(7'h01, 8'h04);
    ov = 1'b1;
    host.step(3);
    chk("ovreq", 8'(c.ov_restart_req), 8'h01);
    ov = 1'b0;
    $display("done ov");
  endtask
  task automatic t_restart();
    wr(7'h01, 8'h27);
    wr(7'h02, 8'h7b);
    fl = 1'b1;
    rs = 1'b1;
    host.step(2);
    rs = 1'b0;
    rd(7'h01, 8'h23);
    rd(7'h02, 8'h5b);
    chk("fo", 8'(c.fail_output), 8'h01);
    fl = 1'b0;
    host.step(3);
    chk("fo0", 8'(c.fail_output), 8'h00);
    $display("done restart");
  endtask
  task automatic t_soft();
    wr(7'h01, 8'hc0);
    rd(7'h01, 8'h00);
    rd(7'h02, 8'h00);
    chk("ovf", 8'(ovf), 8'h00);
    ic = 1'b1;
    host.step(3);
    chk("cfg", 8'(fsc), 8'h01);
    $display("done soft");
  endtask
  initial begin
    rs = 1'b0;
    ov = 1'b0;
    fl = 1'b0;
    wk = 1'b0;
    ld = 1'b0;
    ic = 1'b0;
    repeat (12) @(posedge i_sys_clk);
    #1;
    i_rst = 1'b0;
    host.step(2);
    t_regs();
    t_stop();
    t_ov();
    t_restart();
    t_soft();
    conclude();
  end
  initial begin
    #480000;
    num_errors++;
    conclude();
  end
endmodule // sbc_mode_supply_control_regs_tb_top
